/* File: rtl/ctl_params.svh */
`ifndef CTL_PARAMS_SVH
`define CTL_PARAMS_SVH

// ****************************************************************
// Coprocessor register encodings
// ****************************************************************
`define CTL_MAJOR_CACHE_OPS   4'h7
`define CTL_MAJOR_TLB_OPS     4'h8
`define CTL_MAJOR_CACHE_LOCK  4'h9
`define CTL_MAJOR_TLB_LOCK    4'ha
`define CTL_MINOR_LOCK        4'h0
`define CTL_MINOR_PREFETCH    4'hd
`define CTL_MINOR_TLB_ALL     4'h7
`define CTL_MINOR_TLB_INSTR   4'h5
`define CTL_MINOR_TLB_DATA    4'h6
`define CTL_SEL_DCACHE        3'h0
`define CTL_SEL_ICACHE        3'h1
`define CTL_SEL_PREFETCH      3'h1
`define CTL_SEL_TLB_LOCK      3'h0
`define CTL_SEL_INV_ALL       3'h0
`define CTL_SEL_INV_ONE       3'h1

// ****************************************************************
// Register fields and reset values
// ****************************************************************
`define CTL_LOCK_RESET        4'h0
`define CTL_LOCK_SBO          12'hfff
`define CTL_WAY_FALLBACK      2'h3
`define CTL_VICTIM_LSB        26
`define CTL_PRESERVE_BIT      0
`define CTL_VICTIM_RESET      3'h0

// ****************************************************************
// Lockdown entry compare masks over address bits [31:10]
// ****************************************************************
`define CTL_MASK_SECTION      22'h3ffc00
`define CTL_MASK_LARGE        22'h3fffc0
`define CTL_MASK_LARGE_SUB    22'h3ffff0
`define CTL_MASK_SMALL        22'h3ffffc
`define CTL_MASK_FINE         22'h3fffff

// ****************************************************************
// Controller bus map and command fields
// ****************************************************************
`define CTL_ADDR_CMD          8'h00
`define CTL_ADDR_WDATA        8'h04
`define CTL_ADDR_RDATA        8'h08
`define CTL_ADDR_STATUS       8'h0c
`define CTL_CMD_MAJOR_LSB     0
`define CTL_CMD_MINOR_LSB     4
`define CTL_CMD_SEL_LSB       8
`define CTL_CMD_WRITE_BIT     16

`endif

/* File: rtl/ctl_pkg.sv */
package ctl_pkg;

    // ************************************************************
    // Page kinds reported by a table walk
    // ************************************************************
    typedef enum logic [1:0] {
        CTL_PG_SECTION = 2'h0,
        CTL_PG_LARGE   = 2'h1,
        CTL_PG_SMALL   = 2'h2,
        CTL_PG_TINY    = 2'h3
    } ctl_page_type;

    // ************************************************************
    // Controller sequencer
    // ************************************************************
    typedef enum logic [1:0] {
        CTL_IDLE = 2'b01,
        CTL_BUSY = 2'b10
    } ctl_host_fsm_type;

    // ************************************************************
    // State records
    // ************************************************************
    typedef struct packed {
        logic [3:0]        dlock;
        logic [3:0]        ilock;
        logic              preserve;
        logic [2:0]        victim;
        logic [7:0]        ent_valid;
        logic [7:0][21:0]  ent_addr;
        logic [7:0][21:0]  ent_mask;
        logic              ack;
        logic [31:0]       rdata;
        logic              inv_sa;
        logic              inv_one;
        logic              prefetch;
        logic [31:0]       op_addr;
        logic              hit;
        logic [2:0]        hit_entry;
    } ctl_dev_state_type;

    typedef struct packed {
        ctl_host_fsm_type  fsm;
        logic              write;
        logic [3:0]        major;
        logic [3:0]        minor;
        logic [2:0]        sel;
        logic [31:0]       wdata;
        logic [31:0]       rdata;
        logic [31:0]       hrdata;
        logic              pend_wr;
        logic [7:0]        pend_addr;
    } ctl_host_state_type;

endpackage

/* File: rtl/ctl_cp_if.sv */
interface ctl_cp_if;
    logic        req;
    logic        write;
    logic [3:0]  major_register_field;
    logic [3:0]  minor_register_field;
    logic [2:0]  selector;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;

    modport core (
        output req, write, major_register_field, minor_register_field,
        output selector, wdata,
        input  ack, rdata
    );

    modport device (
        input  req, write, major_register_field, minor_register_field,
        input  selector, wdata,
        output ack, rdata
    );
endinterface

/* File: rtl/ctl_way_pick.sv */
`include "ctl_params.svh"

module ctl_way_pick
    import ctl_pkg::*;
(
    // Lock bits and replacement choice
    input  wire logic [3:0] lock,
    input  wire logic [1:0] candidate,
    // Chosen way
    output logic      [1:0] way
);

    always_comb begin
        way = `CTL_WAY_FALLBACK;
        if (&lock) begin
            way = `CTL_WAY_FALLBACK;
        end else if (!lock[candidate]) begin
            way = candidate;
        end else begin
            for (int i = 3; i >= 0; i--) begin
                if (!lock[i]) begin
                    way = 2'(i);
                end
            end
        end
    end

endmodule

/* File: rtl/ctl_lock_dev.sv */
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`include "ctl_params.svh"

module ctl_lock_dev
    import ctl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                ce,
    // Coprocessor register access
    ctl_cp_if.device                 cp,
    // Linefill way choice, index 0 data cache, 1 instruction cache
    input  wire logic [1:0][1:0]     fill_candidate,
    output logic      [1:0][1:0]     fill_way,
    // Table walk result
    input  wire logic                walk_write,
    input  wire logic [31:0]         walk_modified_virtual_address,
    input  ctl_page_type             walk_page,
    input  wire logic                walk_split_perm,
    output logic                     walk_to_lockdown,
    output logic      [2:0]          walk_victim,
    // Lockdown region probe
    input  wire logic [31:0]         probe_modified_virtual_address,
    output logic                     lock_hit,
    output logic      [2:0]          lock_hit_entry,
    // Maintenance operations passed on
    output logic                     tlb_inv_sa,
    output logic                     tlb_inv_single,
    output logic                     icache_prefetch,
    output logic      [31:0]         op_modified_virtual_address
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [21:0] page_mask(ctl_page_type pg,
                                              logic split);
        logic [21:0] m;
        m = `CTL_MASK_FINE;
        case (pg)
            CTL_PG_SECTION: m = `CTL_MASK_SECTION;
            CTL_PG_LARGE:   m = split ? `CTL_MASK_LARGE_SUB
                                      : `CTL_MASK_LARGE;
            CTL_PG_SMALL:   m = split ? `CTL_MASK_FINE
                                      : `CTL_MASK_SMALL;
            default:        m = `CTL_MASK_FINE;
        endcase
        return m;
    endfunction

    function automatic logic entry_match(logic [31:0] addr,
                                         logic [21:0] tag,
                                         logic [21:0] mask);
        return ((addr[31:10] ^ tag) & mask) == 22'h000000;
    endfunction

    function automatic logic [31:0] lock_word(logic [3:0] lock);
        return {16'h0000, `CTL_LOCK_SBO, lock};
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    ctl_dev_state_type s;
    ctl_dev_state_type next_s;
    logic [7:0]        probe_hit;
    logic [1:0][3:0]   lock_vec;
    logic              take;
    logic              to_cache_lock;
    logic              to_tlb_lock;
    logic              to_tlb_ops;
    logic              to_prefetch;

    assign lock_vec[0] = s.dlock;
    assign lock_vec[1] = s.ilock;

    // ************************************************************
    // Way selection per cache
    // ************************************************************
    generate
        for (genvar c = 0; c < 2; c++) begin : g_cache
            ctl_way_pick u_pick (
                .lock      (lock_vec[c]),
                .candidate (fill_candidate[c]),
                .way       (fill_way[c])
            );
        end
    endgenerate

    // ************************************************************
    // Lockdown entry compare
    // ************************************************************
    generate
        for (genvar e = 0; e < 8; e++) begin : g_probe
            assign probe_hit[e] = s.ent_valid[e]
                && entry_match(probe_modified_virtual_address,
                               s.ent_addr[e], s.ent_mask[e]);
        end
    endgenerate

    // ************************************************************
    // Register decode
    // ************************************************************
    assign take = cp.req && !s.ack;

    always_comb begin
        to_cache_lock = 1'b0;
        to_tlb_lock   = 1'b0;
        to_tlb_ops    = 1'b0;
        to_prefetch   = 1'b0;
        if (cp.major_register_field == `CTL_MAJOR_CACHE_LOCK
            && cp.minor_register_field == `CTL_MINOR_LOCK) begin
            to_cache_lock = 1'b1;
        end else if (cp.major_register_field == `CTL_MAJOR_TLB_LOCK
            && cp.minor_register_field == `CTL_MINOR_LOCK
            && cp.selector == `CTL_SEL_TLB_LOCK) begin
            to_tlb_lock = 1'b1;
        end else if (cp.major_register_field == `CTL_MAJOR_TLB_OPS
            && (cp.minor_register_field == `CTL_MINOR_TLB_ALL
            || cp.minor_register_field == `CTL_MINOR_TLB_INSTR
            || cp.minor_register_field == `CTL_MINOR_TLB_DATA)) begin
            to_tlb_ops = 1'b1;
        end else if (cp.major_register_field == `CTL_MAJOR_CACHE_OPS
            && cp.minor_register_field == `CTL_MINOR_PREFETCH
            && cp.selector == `CTL_SEL_PREFETCH) begin
            to_prefetch = 1'b1;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s          = s;
        next_s.ack      = 1'b0;
        next_s.inv_sa   = 1'b0;
        next_s.inv_one  = 1'b0;
        next_s.prefetch = 1'b0;

        // With preserve set, a walk result lands in the victim entry, then victim moves on
        if (walk_write && s.preserve) begin
            next_s.ent_valid[s.victim] = 1'b1;
            next_s.ent_addr[s.victim]  =
                walk_modified_virtual_address[31:10];
            next_s.ent_mask[s.victim]  =
                page_mask(walk_page, walk_split_perm);
            next_s.victim = 3'(s.victim + 3'h1);
        end

        if (take) begin
            next_s.ack   = 1'b1;
            next_s.rdata = 32'h00000000;
            if (to_cache_lock) begin
                if (cp.selector == `CTL_SEL_DCACHE) begin
                    next_s.rdata = lock_word(s.dlock);
                    if (cp.write) begin
                        next_s.dlock = cp.wdata[3:0];
                    end
                end else if (cp.selector == `CTL_SEL_ICACHE) begin
                    next_s.rdata = lock_word(s.ilock);
                    if (cp.write) begin
                        next_s.ilock = cp.wdata[3:0];
                    end
                end
            end else if (to_tlb_lock) begin
                next_s.rdata[`CTL_VICTIM_LSB +: 3] = s.victim;
                next_s.rdata[`CTL_PRESERVE_BIT]    = s.preserve;
                if (cp.write) begin
                    next_s.victim   = cp.wdata[`CTL_VICTIM_LSB +: 3];
                    next_s.preserve = cp.wdata[`CTL_PRESERVE_BIT];
                end
            end else if (to_tlb_ops && cp.write) begin
                next_s.op_addr = cp.wdata;
                if (cp.selector == `CTL_SEL_INV_ALL) begin
                    next_s.inv_sa = 1'b1;
                end else if (cp.selector == `CTL_SEL_INV_ONE) begin
                    next_s.inv_one = 1'b1;
                    for (int e = 0; e < 8; e++) begin
                        if (entry_match(cp.wdata, next_s.ent_addr[e],
                                        next_s.ent_mask[e])) begin
                            next_s.ent_valid[e] = 1'b0;
                        end
                    end
                end
            end else if (to_prefetch && cp.write) begin
                next_s.op_addr  = cp.wdata;
                next_s.prefetch = 1'b1;
            end
        end

        // Lowest matching lockdown entry reported
        next_s.hit       = |probe_hit;
        next_s.hit_entry = 3'h0;
        for (int e = 7; e >= 0; e--) begin
            if (probe_hit[e]) begin
                next_s.hit_entry = 3'(e);
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s          <= '0;
            s.dlock    <= `CTL_LOCK_RESET;
            s.ilock    <= `CTL_LOCK_RESET;
            s.victim   <= `CTL_VICTIM_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign cp.ack                      = s.ack;
    assign cp.rdata                    = s.rdata;
    assign walk_to_lockdown            = s.preserve;
    assign walk_victim                 = s.victim;
    assign lock_hit                    = s.hit;
    assign lock_hit_entry              = s.hit_entry;
    assign tlb_inv_sa                  = s.inv_sa;
    assign tlb_inv_single              = s.inv_one;
    assign icache_prefetch             = s.prefetch;
    assign op_modified_virtual_address = s.op_addr;

endmodule

/* File: rtl/ctl_cp_host.sv */
`include "ctl_params.svh"

module ctl_cp_host
    import ctl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Coprocessor register access
    ctl_cp_if.core           cp
);

    // ************************************************************
    // Helpers
    // ************************************************************
    ctl_host_state_type s;
    ctl_host_state_type next_s;
    logic               accept;
    logic [31:0]        cmd_word;
    logic [31:0]        wdata_now;

    function automatic logic [31:0] reg_read(logic [7:0] a,
                                             ctl_host_state_type r,
                                             logic [31:0] cmd,
                                             logic [31:0] wd);
        logic [31:0] v;
        v = 32'h00000000;
        if (a == `CTL_ADDR_CMD) begin
            v = cmd;
        end else if (a == `CTL_ADDR_WDATA) begin
            v = wd;
        end else if (a == `CTL_ADDR_RDATA) begin
            v = r.rdata;
        end else if (a == `CTL_ADDR_STATUS) begin
            v = {31'h00000000, r.fsm == CTL_BUSY};
        end
        return v;
    endfunction

    assign accept = hsel && htrans[1] && hready;

    always_comb begin
        cmd_word = 32'h00000000;
        cmd_word[`CTL_CMD_MAJOR_LSB +: 4] = s.major;
        cmd_word[`CTL_CMD_MINOR_LSB +: 4] = s.minor;
        cmd_word[`CTL_CMD_SEL_LSB +: 3]   = s.sel;
        cmd_word[`CTL_CMD_WRITE_BIT]      = s.write;
        wdata_now = s.wdata;
        if (s.pend_wr && s.pend_addr == `CTL_ADDR_WDATA) begin
            wdata_now = hwdata;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s = s;
        if (s.pend_wr) begin
            next_s.pend_wr = 1'b0;
            if (s.pend_addr == `CTL_ADDR_WDATA) begin
                next_s.wdata = hwdata;
            end else if (s.pend_addr == `CTL_ADDR_CMD
                         && s.fsm == CTL_IDLE) begin
                // One access at a time keeps software order
                next_s.major = hwdata[`CTL_CMD_MAJOR_LSB +: 4];
                next_s.minor = hwdata[`CTL_CMD_MINOR_LSB +: 4];
                next_s.sel   = hwdata[`CTL_CMD_SEL_LSB +: 3];
                next_s.write = hwdata[`CTL_CMD_WRITE_BIT];
                next_s.fsm   = CTL_BUSY;
            end
        end
        if (accept) begin
            next_s.pend_wr   = hwrite;
            next_s.pend_addr = haddr[7:0];
            if (!hwrite) begin
                next_s.hrdata = reg_read(haddr[7:0], s, cmd_word,
                                         wdata_now);
            end
        end
        case (s.fsm)
            CTL_BUSY: begin
                if (cp.ack) begin
                    next_s.fsm = CTL_IDLE;
                    if (!s.write) begin
                        next_s.rdata = cp.rdata;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s     <= '0;
            s.fsm <= CTL_IDLE;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign hrdata                  = s.hrdata;
    assign hreadyout               = 1'b1;
    assign hresp                   = 1'b0;
    assign cp.req                  = s.fsm == CTL_BUSY;
    assign cp.write                = s.write;
    assign cp.major_register_field = s.major;
    assign cp.minor_register_field = s.minor;
    assign cp.selector             = s.sel;
    assign cp.wdata                = s.wdata;

endmodule

/* File: testbench/ctl_lock_sva.sv */
module ctl_lock_sva (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Coprocessor link
    input  wire logic        req,
    input  wire logic        write,
    input  wire logic [3:0]  major_register_field,
    input  wire logic [3:0]  minor_register_field,
    input  wire logic [2:0]  selector,
    input  wire logic [31:0] wdata,
    input  wire logic        ack,
    input  wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ************************************************************
    // Shadow of the last written lock bits
    // ************************************************************
    logic [3:0] dl;
    logic [3:0] il;
    logic       lk;
    logic       rd;
    assign lk = ack && major_register_field == 4'h9
                && minor_register_field == 4'h0;
    assign rd = ack && !write;
    always_ff @(posedge clk)
        if (sys_rst) dl <= 4'h0;
        else if (lk && write && selector == 3'h0) dl <= wdata[3:0];
    always_ff @(posedge clk)
        if (sys_rst) il <= 4'h0;
        else if (lk && write && selector == 3'h1) il <= wdata[3:0];

    // ************************************************************
    // Link and register checks
    // ************************************************************
    chk_ack_after_req: assert property (
        $rose(req) |=> ack) else $error("no ack after request");
    chk_ack_one_cycle: assert property (
        ack |=> !ack) else $error("ack longer than one cycle");
    chk_ack_needs_req: assert property (
        ack |-> $past(req)) else $error("ack without request");
    chk_req_held: assert property (
        req && !ack |=> req && $stable(wdata)
        && $stable(major_register_field)) else $error("request dropped");
    chk_dlock_read: assert property (
        lk && !write && selector == 3'h0 |-> rdata == {16'h0, 12'hfff, dl})
        else $error("data lock read wrong");
    chk_ilock_read: assert property (
        lk && !write && selector == 3'h1 |-> rdata == {16'h0, 12'hfff, il})
        else $error("instr lock read wrong");
    chk_tlb_lock_fmt: assert property (
        rd && major_register_field == 4'ha && selector == 3'h0
        |-> rdata[25:1] == 25'h0 && rdata[31:29] == 3'h0)
        else $error("tlb lock read format wrong");
    chk_ops_read_zero: assert property (
        rd && major_register_field == 4'h8 |-> rdata == 32'h0)
        else $error("tlb ops read not zero");
endmodule

/* File: testbench/cache_tlb_lock_victim_ctrl_tb_top.sv */
module cache_tlb_lock_victim_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ctl_pkg::*;
    logic            clk = 1'b0;
    logic            sys_rst = 1'b1;
    logic            hsel = 1'b0;
    logic [31:0]     haddr = 32'h0;
    logic [1:0]      htrans = 2'h0;
    logic            hwrite = 1'b0;
    logic [31:0]     hwdata = 32'h0;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic [1:0][1:0] cand = '0;
    logic [1:0][1:0] fway;
    logic            ww = 1'b0;
    logic [31:0]     wa = 32'h0;
    ctl_page_type    wp = CTL_PG_SECTION;
    logic            wsp = 1'b0;
    logic            to_lock;
    logic [2:0]      vict;
    logic [31:0]     pa = 32'h0;
    logic            hit;
    logic [2:0]      hent;
    logic            rd_pend = 1'b0;
    logic [31:0]     exp_q[$];
    int              failures = 0;
    int              total_checks = 0;
    int              seed = 23;
    wire  [2:0]      pls;
    logic [31:0]     opa;
    logic [2:0]      seen = 3'h0;
    ctl_cp_if        cp ();
    always #5 clk = ~clk;
    always @(posedge clk) if (!sys_rst) seen <= seen | pls;

    ctl_cp_host u_ctl_cp_host (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .cp(cp.core));
    ctl_lock_dev u_ctl_lock_dev (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
        .cp(cp.device), .fill_candidate(cand), .fill_way(fway),
        .walk_write(ww), .walk_modified_virtual_address(wa),
        .walk_page(wp), .walk_split_perm(wsp), .walk_to_lockdown(to_lock),
        .walk_victim(vict), .probe_modified_virtual_address(pa),
        .lock_hit(hit), .lock_hit_entry(hent), .tlb_inv_sa(pls[0]),
        .tlb_inv_single(pls[1]), .icache_prefetch(pls[2]),
        .op_modified_virtual_address(opa));
    ctl_lock_sva u_ctl_lock_sva (.clk(clk), .sys_rst(sys_rst),
        .req(cp.req), .write(cp.write),
        .major_register_field(cp.major_register_field),
        .minor_register_field(cp.minor_register_field),
        .selector(cp.selector), .wdata(cp.wdata), .ack(cp.ack),
        .rdata(cp.rdata));

    // ************************************************************
    // Compare, closing and bus tasks
    // ************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) begin
            failures++;
            report_and_stop;
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        r = hrdata;
    endtask
    // A read notes d as the expected result and fetches it
    task automatic cp_op(input logic w, input logic [3:0] mj, mn,
                         input logic [2:0] sl, input logic [31:0] d);
        logic [31:0] r;
        int n;
        ahb(1'b1, 8'h04, d, r);
        ahb(1'b1, 8'h00, {15'h0, w, 5'h0, sl, mn, mj}, r);
        n = 0;
        do begin
            ahb(1'b0, 8'h0c, 32'h0, r);
            n++;
        end while (r[0] !== 1'b0 && n < 20);
        if (n >= 20) begin
            failures++;
            report_and_stop;
        end
        if (!w) begin
            exp_q.push_back(d);
            ahb(1'b0, 8'h08, 32'h0, r);
        end
    endtask
    task automatic walk(input logic [31:0] a, input ctl_page_type p,
                        input logic s);
        @(posedge clk);
        ww <= 1'b1;
        wa <= a;
        wp <= p;
        wsp <= s;
        @(posedge clk);
        ww <= 1'b0;
    endtask
    task automatic probe(input logic [31:0] a, input logic [3:0] exp);
        pa <= a;
        @(posedge clk);
        @(posedge clk);
        check({28'h0, hit, hit ? hent : 3'h0}, {28'h0, exp});
    endtask
    function automatic logic [1:0] pick(input logic [3:0] l,
                                        input logic [1:0] c);
        if (l == 4'hf) return 2'h3;
        if (!l[c]) return c;
        for (int i = 0; i < 4; i++)
            if (!l[i]) return i[1:0];
        return 2'h3;
    endfunction

    // Read data of RDATA and unmapped reads against the oldest note
    always @(posedge clk) begin
        if (rd_pend && hreadyout === 1'b1)
            check(hrdata, exp_q.pop_front());
        if (hreadyout === 1'b1)
            rd_pend = hsel && htrans[1] && !hwrite
                      && (haddr[7:0] == 8'h08 || haddr[7:0] == 8'h40);
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        logic [31:0] r;
        logic [31:0] x;
        logic [3:0]  v;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        cp_op(1'b0, 4'h9, 4'h0, 3'h0, 32'h0000_fff0);
        cp_op(1'b0, 4'h9, 4'h0, 3'h1, 32'h0000_fff0);
        cp_op(1'b0, 4'ha, 4'h0, 3'h0, 32'h0);
        cp_op(1'b0, 4'h8, 4'h7, 3'h0, 32'h0);
        for (int k = 0; k < 32; k++) begin
            v = k[3:0];
            x = $random(seed);
            cp_op(1'b1, 4'h9, 4'h0, {2'h0, k[4]}, {x[31:4], v});
            cp_op(1'b0, 4'h9, 4'h0, {2'h0, k[4]}, {20'h0fff, v});
            cand[k[4]] <= x[1:0];
            @(posedge clk);
            check({30'h0, fway[k[4]]}, {30'h0, pick(v, x[1:0])});
        end
        cp_op(1'b1, 4'ha, 4'h0, 3'h0, 32'h1800_0001);
        walk(32'h1000_0000, CTL_PG_SMALL, 1'b1);
        walk(32'h2000_0000, CTL_PG_SECTION, 1'b0);
        walk(32'h3000_0000, CTL_PG_TINY, 1'b0);
        cp_op(1'b0, 4'ha, 4'h0, 3'h0, 32'h0400_0001);
        check({28'h0, to_lock, vict}, 32'h9);
        probe(32'h1000_0010, 4'he);
        probe(32'h1000_0400, 4'h0);
        probe(32'h3000_0000, 4'h8);
        cp_op(1'b1, 4'h8, 4'h7, 3'h0, 32'h0);
        probe(32'h2000_0000, 4'hf);
        cp_op(1'b1, 4'h8, 4'h7, 3'h1, 32'h2000_0000);
        probe(32'h2000_0000, 4'h0);
        cp_op(1'b1, 4'ha, 4'h0, 3'h0, 32'h0400_0000);
        walk(32'h4000_0000, CTL_PG_SECTION, 1'b0);
        cp_op(1'b0, 4'ha, 4'h0, 3'h0, 32'h0400_0000);
        probe(32'h4000_0000, 4'h0);
        cp_op(1'b1, 4'h7, 4'hd, 3'h1, 32'h5000_0000);
        check({seen, opa[28:0]}, 32'hf000_0000);
        exp_q.push_back(32'h0);
        ahb(1'b0, 8'h40, 32'h0, r);
        @(posedge clk);
        report_and_stop;
    end
endmodule
